// File: logic/exec_slice_regs.vh
// exec_slice_regs.vh: constants for the load, jump, increment and block executor.
// assumes it is included by bare name from the executor module, the monitor and the bench.
`ifndef EXEC_SLICE_REGS_VH
`define EXEC_SLICE_REGS_VH

// ****************************************
// operation codes on op_in
// ****************************************
`define OP_INC_MEM 5'h00
`define OP_INC_REG 5'h01
`define OP_INC_PAIR 5'h02
`define OP_PORT_IN_DOWN 5'h03
`define OP_PORT_IN_UP 5'h04
`define OP_ABS_BRANCH 5'h05
`define OP_PAIR_BRANCH 5'h06
`define OP_REL_BRANCH 5'h07
`define OP_ACC_FROM_VEC 5'h08
`define OP_ACC_FROM_RFSH 5'h09
`define OP_VEC_FROM_ACC 5'h0A
`define OP_RFSH_FROM_ACC 5'h0B
`define OP_STORE_IMM 5'h0C
`define OP_STORE_REG 5'h0D
`define OP_STORE_PAIR 5'h0E
`define OP_MOVE_REG 5'h0F
`define OP_LOAD_PAIR_MEM 5'h10
`define OP_LOAD_PAIR_IMM 5'h11
`define OP_LOAD_STK 5'h12
`define OP_BLOCK_DOWN 5'h13
`define OP_BLOCK_UP 5'h14

// ****************************************
// register file indices and pair selects
// ****************************************
`define REG_B 3'h0
`define REG_C 3'h1
`define REG_D 3'h2
`define REG_E 3'h3
`define REG_H 3'h4
`define REG_L 3'h5
`define REG_A 3'h7
`define PAIR_CNT 2'h0
`define PAIR_TGT 2'h1
`define PAIR_PTR 2'h2
`define PAIR_STK 2'h3

// ****************************************
// reset values
// ****************************************
`define RST_BYTE 8'h00
`define RST_WORD 16'h0000

`endif

// File: logic/exec_slice.v
// exec_slice.v: executor for increments, block port input, branches, loads and block moves.
// assumes memory and port slaves on the same clock answering each request with a one-cycle ack.
//
// Summary of operation
// - memory increment reads, adds one, writes back
// - register increment adds one in place
// - pair increment adds one to 16-bit pair
// - port input down stores, lowers pointer and count
// - repeating port input down runs until count zero
// - port input up stores, raises pointer, lowers count
// - repeating port input up stops at count zero
// - conditional absolute branch loads target when true
// - unconditional absolute branch always loads target
// - pair branch loads program counter from pair
// - unconditional relative branch adds displacement always
// - conditional relative branch adds displacement when true
// - accumulator loaded from vector or refresh
// - vector or refresh loaded from accumulator
// - immediate byte stored at addressed location
// - selected register stored at addressed location
// - pair stored as two bytes at address
// - register copied to register, source unchanged
// - pair loaded from memory or immediate
// - stack pointer loaded from selected pair
// - block move down copies, lowers pointers, counter
// - block move up copies, raises pointers, lowers counter
`timescale 1ns/1ps
`include "exec_slice_regs.vh"

module exec_slice (
  // clock and reset
  input wire clk_in,
  input wire rstn_in,
  // command
  input wire start_in,
  input wire [4:0] op_in,
  input wire repeat_in,
  input wire cond_en_in,
  input wire cond_in,
  input wire [2:0] dst_sel_in,
  input wire [2:0] src_sel_in,
  input wire [1:0] pair_sel_in,
  input wire [15:0] imm_in,
  input wire [7:0] disp_in,
  output wire busy_out,
  output wire done_out,
  // memory bus
  output wire mem_req_out,
  output wire mem_we_out,
  output wire [15:0] mem_addr_out,
  output wire [7:0] mem_wdata_out,
  input wire [7:0] mem_rdata_in,
  input wire mem_ack_in,
  // port bus
  output wire io_req_out,
  output wire [7:0] io_addr_out,
  input wire [7:0] io_rdata_in,
  input wire io_ack_in,
  // register views
  output wire [15:0] pc_out,
  output wire [15:0] stk_out,
  output wire [7:0] acc_out,
  output wire [15:0] counter_out
);

  // ****************************************
  // states
  // ****************************************
  localparam S_IDLE = 2'h0;
  localparam S_RD = 2'h1;
  localparam S_WR = 2'h2;
  localparam S_IO = 2'h3;

  // ****************************************
  // storage
  // ****************************************
  reg [7:0] gpr_reg [0:7]; // byte registers, index 6 spare
  reg [15:0] pc_reg; // address after the current instruction
  reg [15:0] stk_reg; // stack pointer
  reg [7:0] vec_reg; // interrupt vector register
  reg [7:0] rfsh_reg; // refresh register
  reg [1:0] state_reg; // sequencer state
  reg [4:0] op_reg; // latched operation
  reg rep_reg; // latched repeat request
  reg [1:0] pair_reg; // latched pair select
  reg [7:0] lo_reg; // low byte held between two reads
  reg hi_reg; // second byte of a word transfer
  reg done_reg; // completion pulse
  reg mem_req_reg; // memory request held until ack
  reg mem_we_reg; // write strobe qualifier
  reg [15:0] mem_addr_reg; // memory address
  reg [7:0] mem_wdata_reg; // memory write data
  reg io_req_reg; // port request held until ack
  reg [7:0] io_addr_reg; // port address
  integer i;

  // read one pair by select; used for branches, loads and updates
  function [15:0] pair_get;
    input [1:0] sel;
    begin
      case (sel)
        `PAIR_CNT: pair_get = {gpr_reg[`REG_B], gpr_reg[`REG_C]};
        `PAIR_TGT: pair_get = {gpr_reg[`REG_D], gpr_reg[`REG_E]};
        `PAIR_PTR: pair_get = {gpr_reg[`REG_H], gpr_reg[`REG_L]};
        default: pair_get = stk_reg;
      endcase
    end
  endfunction

  // pointer and counter views
  wire [15:0] ptr_w = pair_get(`PAIR_PTR);
  wire [15:0] tgt_w = pair_get(`PAIR_TGT);
  wire [15:0] cnt_w = pair_get(`PAIR_CNT);
  wire [15:0] sel_pair_w = pair_get(pair_sel_in); // pair named by the command
  wire [15:0] held_pair_w = pair_get(pair_reg); // latched pair, for the second byte
  wire [7:0] b_dec_w = gpr_reg[`REG_B] - 8'h01;
  wire [15:0] cnt_dec_w = cnt_w - 16'h0001;
  wire [15:0] disp_ext_w = {{8{disp_in[7]}}, disp_in};
  wire taken_w = ~cond_en_in | cond_in;
  wire down_w = (op_reg == `OP_PORT_IN_DOWN) || (op_reg == `OP_BLOCK_DOWN);
  wire [15:0] step_w = down_w ? 16'hFFFF : 16'h0001;

  // write a pair in place; only called from the sequencer process
  task pair_set;
    input [1:0] sel;
    input [15:0] val;
    begin
      case (sel)
        `PAIR_CNT: begin
          gpr_reg[`REG_B] <= val[15:8];
          gpr_reg[`REG_C] <= val[7:0];
        end
        `PAIR_TGT: begin
          gpr_reg[`REG_D] <= val[15:8];
          gpr_reg[`REG_E] <= val[7:0];
        end
        `PAIR_PTR: begin
          gpr_reg[`REG_H] <= val[15:8];
          gpr_reg[`REG_L] <= val[7:0];
        end
        default: stk_reg <= val;
      endcase
    end
  endtask

  // ****************************************
  // sequencer and register file
  // ****************************************
  always @(posedge clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      for (i = 0; i < 8; i = i + 1) begin
        gpr_reg[i] <= `RST_BYTE;
      end
      pc_reg <= `RST_WORD;
      stk_reg <= `RST_WORD;
      vec_reg <= `RST_BYTE;
      rfsh_reg <= `RST_BYTE;
      state_reg <= S_IDLE;
      op_reg <= 5'h00;
      rep_reg <= 1'b0;
      pair_reg <= 2'h0;
      lo_reg <= `RST_BYTE;
      hi_reg <= 1'b0;
      done_reg <= 1'b0;
      mem_req_reg <= 1'b0;
      mem_we_reg <= 1'b0;
      mem_addr_reg <= `RST_WORD;
      mem_wdata_reg <= `RST_BYTE;
      io_req_reg <= 1'b0;
      io_addr_reg <= `RST_BYTE;
    end else begin
      done_reg <= 1'b0;
      case (state_reg)
        S_IDLE: begin
          if (start_in) begin
            op_reg <= op_in;
            rep_reg <= repeat_in;
            pair_reg <= pair_sel_in;
            hi_reg <= 1'b0;
            case (op_in)
              // read the location first; increment adds one on the way back, block moves copy it
              `OP_INC_MEM, `OP_BLOCK_DOWN, `OP_BLOCK_UP: begin
                mem_addr_reg <= ptr_w;
                mem_we_reg <= 1'b0;
                mem_req_reg <= 1'b1;
                state_reg <= S_RD;
              end
              `OP_INC_REG: begin
                gpr_reg[dst_sel_in] <= gpr_reg[dst_sel_in] + 8'h01;
                done_reg <= 1'b1;
              end
              `OP_INC_PAIR: begin
                pair_set(pair_sel_in, pair_get(pair_sel_in) + 16'h0001);
                done_reg <= 1'b1;
              end
              // port address always from the select register
              `OP_PORT_IN_DOWN, `OP_PORT_IN_UP: begin
                io_addr_reg <= gpr_reg[`REG_C];
                io_req_reg <= 1'b1;
                state_reg <= S_IO;
              end
              `OP_ABS_BRANCH: begin
                if (taken_w) begin
                  pc_reg <= imm_in;
                end
                done_reg <= 1'b1;
              end
              `OP_PAIR_BRANCH: begin
                pc_reg <= pair_get(pair_sel_in);
                done_reg <= 1'b1;
              end
              // signed offset from the address after the instruction
              `OP_REL_BRANCH: begin
                if (taken_w) begin
                  pc_reg <= pc_reg + disp_ext_w;
                end
                done_reg <= 1'b1;
              end
              `OP_ACC_FROM_VEC, `OP_ACC_FROM_RFSH: begin
                gpr_reg[`REG_A] <= (op_in == `OP_ACC_FROM_VEC) ? vec_reg : rfsh_reg;
                done_reg <= 1'b1;
              end
              `OP_VEC_FROM_ACC: begin
                vec_reg <= gpr_reg[`REG_A];
                done_reg <= 1'b1;
              end
              `OP_RFSH_FROM_ACC: begin
                rfsh_reg <= gpr_reg[`REG_A];
                done_reg <= 1'b1;
              end
              `OP_STORE_IMM, `OP_STORE_REG: begin
                mem_addr_reg <= ptr_w;
                mem_wdata_reg <= (op_in == `OP_STORE_IMM) ? imm_in[7:0] :
                  gpr_reg[src_sel_in];
                mem_we_reg <= 1'b1;
                mem_req_reg <= 1'b1;
                state_reg <= S_WR;
              end
              // low byte at the address, high byte one above
              `OP_STORE_PAIR: begin
                mem_addr_reg <= imm_in;
                mem_wdata_reg <= sel_pair_w[7:0];
                mem_we_reg <= 1'b1;
                mem_req_reg <= 1'b1;
                state_reg <= S_WR;
              end
              `OP_MOVE_REG: begin
                gpr_reg[dst_sel_in] <= gpr_reg[src_sel_in];
                done_reg <= 1'b1;
              end
              `OP_LOAD_PAIR_MEM: begin
                mem_addr_reg <= imm_in;
                mem_we_reg <= 1'b0;
                mem_req_reg <= 1'b1;
                state_reg <= S_RD;
              end
              `OP_LOAD_PAIR_IMM: begin
                pair_set(pair_sel_in, imm_in);
                done_reg <= 1'b1;
              end
              `OP_LOAD_STK: begin
                stk_reg <= sel_pair_w;
                done_reg <= 1'b1;
              end
              // unknown codes finish at once with no effect
              default: begin
                done_reg <= 1'b1;
              end
            endcase
          end
        end
        // memory read answered
        S_RD: begin
          if (mem_ack_in) begin
            case (op_reg)
              `OP_INC_MEM: begin
                mem_wdata_reg <= mem_rdata_in + 8'h01;
                mem_we_reg <= 1'b1;
                state_reg <= S_WR;
              end
              `OP_LOAD_PAIR_MEM: begin
                if (!hi_reg) begin
                  lo_reg <= mem_rdata_in;
                  mem_addr_reg <= mem_addr_reg + 16'h0001;
                  hi_reg <= 1'b1;
                end else begin
                  pair_set(pair_reg, {mem_rdata_in, lo_reg});
                  mem_req_reg <= 1'b0;
                  done_reg <= 1'b1;
                  state_reg <= S_IDLE;
                end
              end
              // block move: source byte goes to the target pointer
              default: begin
                mem_addr_reg <= tgt_w;
                mem_wdata_reg <= mem_rdata_in;
                mem_we_reg <= 1'b1;
                state_reg <= S_WR;
              end
            endcase
          end
        end
        // memory write answered
        S_WR: begin
          if (mem_ack_in) begin
            mem_req_reg <= 1'b0;
            mem_we_reg <= 1'b0;
            state_reg <= S_IDLE;
            case (op_reg)
              // pointer moves one way, count always down
              `OP_PORT_IN_DOWN, `OP_PORT_IN_UP: begin
                pair_set(`PAIR_PTR, ptr_w + step_w);
                gpr_reg[`REG_B] <= b_dec_w;
                if (rep_reg && b_dec_w != 8'h00) begin
                  io_req_reg <= 1'b1;
                  state_reg <= S_IO;
                end else begin
                  done_reg <= 1'b1;
                end
              end
              `OP_BLOCK_DOWN, `OP_BLOCK_UP: begin
                pair_set(`PAIR_PTR, ptr_w + step_w);
                pair_set(`PAIR_TGT, tgt_w + step_w);
                pair_set(`PAIR_CNT, cnt_dec_w);
                if (rep_reg && cnt_dec_w != 16'h0000) begin
                  mem_addr_reg <= ptr_w + step_w;
                  mem_req_reg <= 1'b1;
                  state_reg <= S_RD;
                end else begin
                  done_reg <= 1'b1;
                end
              end
              `OP_STORE_PAIR: begin
                if (!hi_reg) begin
                  hi_reg <= 1'b1;
                  mem_addr_reg <= mem_addr_reg + 16'h0001;
                  mem_wdata_reg <= held_pair_w[15:8];
                  mem_req_reg <= 1'b1;
                  mem_we_reg <= 1'b1;
                  state_reg <= S_WR;
                end else begin
                  done_reg <= 1'b1;
                end
              end
              default: begin
                done_reg <= 1'b1;
              end
            endcase
          end
        end
        // port read answered: one byte per read, stored at the pointer
        S_IO: begin
          if (io_ack_in) begin
            io_req_reg <= 1'b0;
            mem_addr_reg <= ptr_w;
            mem_wdata_reg <= io_rdata_in;
            mem_we_reg <= 1'b1;
            mem_req_reg <= 1'b1;
            state_reg <= S_WR;
          end
        end
        default: begin
          state_reg <= S_IDLE;
        end
      endcase
    end
  end

  // ****************************************
  // outputs
  // ****************************************
  assign busy_out = (state_reg != S_IDLE); // command accepted only while low
  assign done_out = done_reg;
  assign mem_req_out = mem_req_reg;
  assign mem_we_out = mem_we_reg;
  assign mem_addr_out = mem_addr_reg;
  assign mem_wdata_out = mem_wdata_reg;
  assign io_req_out = io_req_reg;
  assign io_addr_out = io_addr_reg;
  assign pc_out = pc_reg;
  assign stk_out = stk_reg;
  assign acc_out = gpr_reg[`REG_A];
  assign counter_out = cnt_w;

endmodule // exec_slice

// File: test/mem_io_model.sv
// mem_io_model.sv: byte memory and input ports that answer the executor's two buses.
// assumes every request is held until its ack, one request outstanding per bus.
`timescale 1ns/1ps
module mem_io_model (
  // clock and pacing
  input wire logic clk_in,
  input wire logic slow_in,
  // memory bus
  input wire logic mem_req_in,
  input wire logic mem_we_in,
  input wire logic [15:0] mem_addr_in,
  input wire logic [7:0] mem_wdata_in,
  output logic [7:0] mem_rdata_out,
  output logic mem_ack_out,
  // port bus
  input wire logic io_req_in,
  input wire logic [7:0] io_addr_in,
  output logic [7:0] io_rdata_out,
  output logic io_ack_out
);
  logic [7:0] mem [0:65535]; // byte store, preloaded by the bench
  logic [7:0] io_seq_reg = 8'h30; // next byte a port hands out
  int mem_wait = 0; // cycles still to stall the memory
  int io_wait = 0; // cycles still to stall the port
  initial begin
    mem_ack_out = 1'b0;
    io_ack_out = 1'b0;
    mem_rdata_out = 8'h00;
    io_rdata_out = 8'h00;
  end
  // memory: one byte per ack, data only valid with the ack
  always @(posedge clk_in) begin
    mem_ack_out <= 1'b0;
    mem_rdata_out <= ~mem_rdata_out;
    if (mem_req_in && !mem_ack_out) begin
      if (mem_wait > 0) begin
        mem_wait <= mem_wait - 1;
      end else begin
        mem_ack_out <= 1'b1;
        mem_wait <= slow_in ? 1 + ($urandom % 4) : 0;
        if (mem_we_in)
          mem[mem_addr_in] <= mem_wdata_in;
        else
          mem_rdata_out <= mem[mem_addr_in];
      end
    end
  end
  // port: one byte per read cycle, a new value each time
  always @(posedge clk_in) begin
    io_ack_out <= 1'b0;
    io_rdata_out <= ~io_rdata_out;
    if (io_req_in && !io_ack_out) begin
      if (io_wait > 0) begin
        io_wait <= io_wait - 1;
      end else begin
        io_ack_out <= 1'b1;
        io_wait <= slow_in ? 1 + ($urandom % 4) : 0;
        io_rdata_out <= io_seq_reg;
        io_seq_reg <= io_seq_reg + 8'h01;
      end
    end
  end
endmodule // mem_io_model

// File: test/exec_slice_monitor.sv
// exec_slice_monitor.sv: port assertions for the executor.
// assumes one clock and an asynchronous active-low reset.
`timescale 1ns/1ps
`include "exec_slice_regs.vh"
module exec_slice_monitor (
  // clock and reset
  input wire logic clk_in,
  input wire logic rstn_in,
  // command
  input wire logic start_in,
  input wire logic [4:0] op_in,
  input wire logic cond_en_in,
  input wire logic cond_in,
  input wire logic [1:0] pair_sel_in,
  input wire logic [15:0] imm_in,
  input wire logic [7:0] disp_in,
  input wire logic busy_out,
  // views
  input wire logic io_req_out,
  input wire logic [7:0] io_addr_out,
  input wire logic [15:0] pc_out,
  input wire logic [15:0] stk_out,
  input wire logic [15:0] counter_out
);
  wire logic take = start_in && !busy_out; // command accepted
  wire logic met = !cond_en_in || cond_in; // branch condition holds
  wire logic cnt_sel = pair_sel_in == `PAIR_CNT; // counter pair chosen
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (!rstn_in);
  property p_abs_go;
    take && op_in == `OP_ABS_BRANCH && met |=> pc_out == $past(imm_in);
  endproperty
  a_abs_go: assert property (p_abs_go) else $error("target not loaded");
  property p_abs_skip;
    take && op_in == `OP_ABS_BRANCH && !met |=> $stable(pc_out);
  endproperty
  a_abs_skip: assert property (p_abs_skip) else $error("false branch moved pc");
  property p_rel_go;
    take && op_in == `OP_REL_BRANCH && met
      |=> pc_out == $past(pc_out) + {{8{$past(disp_in[7])}}, $past(disp_in)};
  endproperty
  a_rel_go: assert property (p_rel_go) else $error("relative target wrong");
  property p_rel_skip;
    take && op_in == `OP_REL_BRANCH && !met |=> $stable(pc_out);
  endproperty
  a_rel_skip: assert property (p_rel_skip) else $error("false relative moved pc");
  property p_pair_jump;
    take && op_in == `OP_PAIR_BRANCH && cnt_sel |=> pc_out == $past(counter_out);
  endproperty
  a_pair_jump: assert property (p_pair_jump) else $error("pair branch wrong");
  property p_stk_load;
    take && op_in == `OP_LOAD_STK && cnt_sel |=> stk_out == $past(counter_out);
  endproperty
  a_stk_load: assert property (p_stk_load) else $error("stack pointer load wrong");
  property p_pair_inc;
    take && op_in == `OP_INC_PAIR && cnt_sel |=> counter_out == $past(counter_out) + 16'h0001;
  endproperty
  a_pair_inc: assert property (p_pair_inc) else $error("pair increment wrong");
  property p_pair_imm;
    take && op_in == `OP_LOAD_PAIR_IMM && cnt_sel |=> counter_out == $past(imm_in);
  endproperty
  a_pair_imm: assert property (p_pair_imm) else $error("pair immediate wrong");
  property p_port_addr;
    io_req_out |-> io_addr_out == counter_out[7:0];
  endproperty
  a_port_addr: assert property (p_port_addr) else $error("port address wrong");
  // main scenarios reached
  c_block: cover property (take && op_in == `OP_BLOCK_UP);
  c_port: cover property (io_req_out);
  c_rel_skip: cover property (take && op_in == `OP_REL_BRANCH && !met);
endmodule // exec_slice_monitor
bind exec_slice exec_slice_monitor u_mon (.clk_in(clk_in), .rstn_in(rstn_in),
  .start_in(start_in), .op_in(op_in), .cond_en_in(cond_en_in), .cond_in(cond_in),
  .pair_sel_in(pair_sel_in), .imm_in(imm_in), .disp_in(disp_in), .busy_out(busy_out),
  .io_req_out(io_req_out), .io_addr_out(io_addr_out), .pc_out(pc_out), .stk_out(stk_out),
  .counter_out(counter_out));

// File: test/tb_top.sv
// tb_top.sv: self-checking bench for the executor with a memory and port model.
// assumes the executor's header; results are queued and checked on each done pulse.
`timescale 1ns/1ps
`include "exec_slice_regs.vh"
module tb_top;
  logic clk_in = 1'b0;
  logic rstn_in = 1'b0;
  logic start_in = 1'b0;
  logic [4:0] op_in = 5'h00;
  logic [2:0] fl = 3'h0; // repeat, conditional, condition
  logic [2:0] dst_sel_in = 3'h0;
  logic [2:0] src_sel_in = 3'h0;
  logic [1:0] pair_sel_in = 2'h0;
  logic [15:0] imm_in = 16'h0000;
  logic [7:0] disp_in = 8'h00;
  logic slow = 1'b0;
  wire busy_out, done_out, mem_req, mem_we, mem_ack, io_req, io_ack;
  wire [15:0] mem_addr, pc_out, stk_out, counter_out;
  wire [7:0] mem_wdata, mem_rdata, io_addr, io_rdata, acc_out;
  int n_mismatch = 0;
  int n_compared = 0;
  int q_sel [$];
  logic [15:0] q_val [$];
  logic [15:0] rv, rw;
  exec_slice dut (.clk_in(clk_in), .rstn_in(rstn_in), .start_in(start_in), .op_in(op_in),
    .repeat_in(fl[2]), .cond_en_in(fl[1]), .cond_in(fl[0]), .dst_sel_in(dst_sel_in),
    .src_sel_in(src_sel_in), .pair_sel_in(pair_sel_in), .imm_in(imm_in), .disp_in(disp_in),
    .busy_out(busy_out), .done_out(done_out), .mem_req_out(mem_req), .mem_we_out(mem_we),
    .mem_addr_out(mem_addr), .mem_wdata_out(mem_wdata), .mem_rdata_in(mem_rdata),
    .mem_ack_in(mem_ack), .io_req_out(io_req), .io_addr_out(io_addr), .io_rdata_in(io_rdata),
    .io_ack_in(io_ack), .pc_out(pc_out), .stk_out(stk_out), .acc_out(acc_out),
    .counter_out(counter_out));
  mem_io_model mem_model (.clk_in(clk_in), .slow_in(slow), .mem_req_in(mem_req),
    .mem_we_in(mem_we), .mem_addr_in(mem_addr), .mem_wdata_in(mem_wdata),
    .mem_rdata_out(mem_rdata), .mem_ack_out(mem_ack), .io_req_in(io_req), .io_addr_in(io_addr),
    .io_rdata_out(io_rdata), .io_ack_out(io_ack));
  initial begin
    forever #5 clk_in = ~clk_in;
  end
  // ****************************************
  // reporting and comparing
  // ****************************************
  task automatic end_of_test();
    $display("compared %0d mismatched %0d", n_compared, n_mismatch);
    if (n_mismatch == 0 && n_compared > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask
  task automatic check(input logic [15:0] got, input logic [15:0] exp);
    n_compared++;
    if (got !== exp) begin
      n_mismatch++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  // register view named by sel: 0 pc, 1 stack, 2 acc, 3 counter, else none
  task automatic cmp_view(input int sel, input logic [15:0] exp);
    case (sel)
      0: check(pc_out, exp);
      1: check(stk_out, exp);
      2: check({8'h00, acc_out}, exp);
      3: check(counter_out, exp);
      default: ;
    endcase
  endtask
  task automatic cmp_mem(input logic [15:0] a, input logic [7:0] exp);
    check({8'h00, mem_model.mem[a]}, {8'h00, exp});
  endtask
  // watcher: oldest note is compared on every done pulse
  always @(negedge clk_in) begin
    if (done_out === 1'b1) begin
      if (q_sel.size() == 0)
        check(16'h0000, 16'hffff);
      else
        cmp_view(q_sel.pop_front(), q_val.pop_front());
    end
  end
  // one command: note expectation, pulse start, wait for done
  task automatic cmd(input logic [4:0] o, input logic [2:0] f, input logic [2:0] d,
    input logic [2:0] s, input logic [1:0] p, input logic [15:0] imm, input logic [7:0] dsp,
    input int sel, input logic [15:0] exp);
    int k;
    @(posedge clk_in);
    #1;
    q_sel.push_back(sel);
    q_val.push_back(exp);
    {start_in, op_in, fl, dst_sel_in, src_sel_in} = {1'b1, o, f, d, s};
    {pair_sel_in, imm_in, disp_in} = {p, imm, dsp};
    @(posedge clk_in);
    #1;
    start_in = 1'b0;
    for (k = 0; k < 3000 && done_out !== 1'b1; k++)
      @(negedge clk_in);
    if (k == 3000)
      check(16'h0000, 16'hffff);
  endtask
  task automatic lp(input logic [1:0] p, input logic [15:0] v);
    cmd(`OP_LOAD_PAIR_IMM, 3'h0, 3'h0, 3'h0, p, v, 8'h00, 4, 16'h0000);
  endtask
  // ****************************************
  // tests
  // ****************************************
  initial begin
    rv = $urandom(32'h46ac786e);
    repeat (3) @(posedge clk_in);
    #1 rstn_in = 1'b1;
    cmd(`OP_LOAD_PAIR_IMM, 3'h0, 3'h0, 3'h0, `PAIR_CNT, 16'h00ff, 8'h00, 3, 16'h00ff);
    cmd(`OP_INC_PAIR, 3'h0, 3'h0, 3'h0, `PAIR_CNT, 16'h0000, 8'h00, 3, 16'h0100);
    cmd(`OP_LOAD_STK, 3'h0, 3'h0, 3'h0, `PAIR_CNT, 16'h0000, 8'h00, 1, 16'h0100);
    cmd(`OP_PAIR_BRANCH, 3'h0, 3'h0, 3'h0, `PAIR_CNT, 16'h0000, 8'h00, 0, 16'h0100);
    rv = $urandom;
    cmd(`OP_ABS_BRANCH, 3'h0, 3'h0, 3'h0, 2'h0, rv, 8'h00, 0, rv);
    cmd(`OP_ABS_BRANCH, 3'h2, 3'h0, 3'h0, 2'h0, ~rv, 8'h00, 0, rv);
    cmd(`OP_ABS_BRANCH, 3'h3, 3'h0, 3'h0, 2'h0, ~rv, 8'h00, 0, ~rv);
    cmd(`OP_REL_BRANCH, 3'h0, 3'h0, 3'h0, 2'h0, 16'h0000, 8'hf0, 0, ~rv - 16'h0010);
    cmd(`OP_REL_BRANCH, 3'h2, 3'h0, 3'h0, 2'h0, 16'h0000, 8'h7f, 0, ~rv - 16'h0010);
    cmd(`OP_REL_BRANCH, 3'h3, 3'h0, 3'h0, 2'h0, 16'h0000, 8'h7f, 0, ~rv + 16'h006f);
    $display("test branches done");
    cmd(`OP_INC_REG, 3'h0, `REG_A, 3'h0, 2'h0, 16'h0000, 8'h00, 2, 16'h0001);
    for (int i = 0; i < 2; i++) begin
      cmd(`OP_VEC_FROM_ACC + 5'(i), 3'h0, 3'h0, 3'h0, 2'h0, 16'h0, 8'h00, 4, 16'h0);
      cmd(`OP_INC_REG, 3'h0, `REG_A, 3'h0, 2'h0, 16'h0000, 8'h00, 2, 16'h0002);
      cmd(`OP_ACC_FROM_VEC + 5'(i), 3'h0, 3'h0, 3'h0, 2'h0, 16'h0, 8'h00, 2, 16'h1);
    end
    rv = $urandom;
    lp(`PAIR_CNT, rv);
    cmd(`OP_MOVE_REG, 3'h0, `REG_A, `REG_C, 2'h0, 16'h0000, 8'h00, 2, rv[7:0]);
    cmd(`OP_MOVE_REG, 3'h0, `REG_B, `REG_A, 2'h0, 16'h0, 8'h00, 3, {2{rv[7:0]}});
    $display("test registers done");
    slow = 1'b1;
    mem_model.mem[16'h2000] = 8'hff;
    lp(`PAIR_PTR, 16'h2000);
    cmd(`OP_INC_MEM, 3'h0, 3'h0, 3'h0, 2'h0, 16'h0000, 8'h00, 4, 16'h0000);
    cmp_mem(16'h2000, 8'h00);
    rw = $urandom;
    cmd(`OP_STORE_IMM, 3'h0, 3'h0, 3'h0, 2'h0, rw, 8'h00, 4, 16'h0000);
    cmp_mem(16'h2000, rw[7:0]);
    cmd(`OP_STORE_REG, 3'h0, 3'h0, `REG_A, 2'h0, 16'h0000, 8'h00, 4, 16'h0000);
    cmp_mem(16'h2000, rv[7:0]);
    lp(`PAIR_CNT, rw);
    cmd(`OP_STORE_PAIR, 3'h0, 3'h0, 3'h0, `PAIR_CNT, 16'h3000, 8'h00, 4, 16'h0000);
    cmp_mem(16'h3000, rw[7:0]);
    cmp_mem(16'h3001, rw[15:8]);
    cmd(`OP_LOAD_PAIR_MEM, 3'h0, 3'h0, 3'h0, `PAIR_TGT, 16'h3000, 8'h00, 4, 16'h0000);
    cmd(`OP_LOAD_STK, 3'h0, 3'h0, 3'h0, `PAIR_TGT, 16'h0000, 8'h00, 1, rw);
    $display("test memory done");
    for (int i = 0; i < 3; i++)
      mem_model.mem[16'h4000 + i] = 8'($urandom);
    lp(`PAIR_PTR, 16'h4000);
    lp(`PAIR_TGT, 16'h5000);
    lp(`PAIR_CNT, 16'h0003);
    cmd(`OP_BLOCK_UP, 3'h4, 3'h0, 3'h0, 2'h0, 16'h0000, 8'h00, 3, 16'h0000);
    for (int i = 0; i < 3; i++)
      cmp_mem(16'h5000 + i, mem_model.mem[16'h4000 + i]);
    lp(`PAIR_PTR, 16'h4002);
    lp(`PAIR_TGT, 16'h6002);
    lp(`PAIR_CNT, 16'h0002);
    cmd(`OP_BLOCK_DOWN, 3'h0, 3'h0, 3'h0, 2'h0, 16'h0000, 8'h00, 3, 16'h0001);
    cmd(`OP_BLOCK_DOWN, 3'h4, 3'h0, 3'h0, 2'h0, 16'h0000, 8'h00, 3, 16'h0000);
    cmp_mem(16'h6002, mem_model.mem[16'h4002]);
    cmp_mem(16'h6001, mem_model.mem[16'h4001]);
    $display("test block move done");
    lp(`PAIR_PTR, 16'h7000);
    lp(`PAIR_CNT, 16'h0340);
    cmd(`OP_PORT_IN_UP, 3'h4, 3'h0, 3'h0, 2'h0, 16'h0000, 8'h00, 3, 16'h0040);
    for (int i = 0; i < 3; i++)
      cmp_mem(16'h7000 + i, 8'h30 + 8'(i));
    lp(`PAIR_PTR, 16'h7100);
    lp(`PAIR_CNT, 16'h0241);
    cmd(`OP_PORT_IN_DOWN, 3'h0, 3'h0, 3'h0, 2'h0, 16'h0000, 8'h00, 3, 16'h0141);
    cmd(`OP_PORT_IN_DOWN, 3'h4, 3'h0, 3'h0, 2'h0, 16'h0000, 8'h00, 3, 16'h0041);
    cmp_mem(16'h7100, 8'h33);
    cmp_mem(16'h70ff, 8'h34);
    $display("test port input done");
    end_of_test();
  end
  // watchdog well past the expected run length
  initial begin
    #500000;
    n_mismatch++;
    end_of_test();
  end
endmodule // tb_top
